//--- design/ssr_cmd_top.sv
`timescale 1ns/1ns
// What this block does
// - Read-only 16-bit count of transfers of the latest sequential command.
// - Sixty-four 32-bit buffer words at 4-byte spacing, read-only at their addresses.
// - Codes 1..6: read, write, seq read, seq write, buffer read, buffer write.
// - Word 1 of single access is an address up to 0x3FFF.
// - Reply word 0: error bit 15, busy bit 14, echoed address 13:0.
// - Single read data in reply words 1 and 2, flush left, once idle.
// - Word 2 of single write is the value, flush left, then stored.
// - Sequential read fills the buffer words, not the reply.
// - Sequential read reply echoes error, busy and start address.
// - Frames are three 16-bit words, MSB first, select low, clock idles low.
// - Data sampled on falling clock edges, at most 18.75 Mbps.
// - Status register keeps the failure code of the latest bad frame.
module ssr_cmd_top #(
   parameter logic [31:0] DEVICE_ID = 32'h0000_0001, // Arbitrary value
   parameter logic [15:0] REVISION  = 16'h0001       // Arbitrary value
) (
   // System
   input  wire logic              clk,
   input  wire logic              rst,
   // Serial link
   input  wire logic              serial_clock_in,
   input  wire logic              slave_select_n,
   input  wire logic              mosi,
   output logic                   miso,
   // Controller access port
   output ssr_pkg::ssr_ctl_t      ctl_o,
   output logic                   ctl_req,
   input  wire logic [31:0]       ctl_rdata,
   input  wire logic              ctl_ack
);
   import ssr_pkg::*;

   // ***********************
   // Link clock domain
   // ***********************
   logic [5:0]  rx_cnt_reg;
   logic [47:0] rx_sh_reg;
   logic        done_tgl_reg;
   ssr_frame_t  frm_reg;
   logic        tx_first_reg;
   logic [47:0] tx_sh_reg;
   ssr_reply_t  reply_reg;

   // Shift in on falling edges; select high clears the frame state
   always_ff @(negedge serial_clock_in or posedge slave_select_n) begin
      if (slave_select_n) begin
         rx_cnt_reg <= 6'h00;
         rx_sh_reg  <= 48'h0;
      end else begin
         rx_sh_reg  <= {rx_sh_reg[46:0], mosi};
         rx_cnt_reg <= rx_cnt_reg + 6'h01;
      end
   end

   // Frame-done toggles rather than pulses: select rises a few ns after the
   // last bit, far too soon for a level to be caught by the core clock.
   // Reset is only applied while the link is quiet, so its release is safe here
   always_ff @(negedge serial_clock_in or posedge rst) begin
      if (rst) begin
         done_tgl_reg <= 1'b0;
      end else if (!slave_select_n && rx_cnt_reg == LAST_BIT) begin
         done_tgl_reg <= ~done_tgl_reg;
      end
   end

   // Frame word held until the next frame completes, so the core reads it stable
   always_ff @(negedge serial_clock_in) begin
      if (!slave_select_n && rx_cnt_reg == LAST_BIT) begin
         frm_reg <= {rx_sh_reg[46:0], mosi};
      end
   end

   // Reply shifts out on rising edges so the master samples it on falling ones
   always_ff @(posedge serial_clock_in or posedge slave_select_n) begin
      if (slave_select_n) begin
         tx_first_reg <= 1'b1;
         tx_sh_reg    <= 48'h0;
         miso         <= 1'b0;
      end else begin
         tx_first_reg <= 1'b0;
         if (tx_first_reg) begin
            miso      <= reply_reg[47];
            tx_sh_reg <= {reply_reg[46:0], 1'b0};
         end else begin
            miso      <= tx_sh_reg[47];
            tx_sh_reg <= {tx_sh_reg[46:0], 1'b0};
         end
      end
   end

   // ***********************
   // Crossing into the core
   // ***********************
   logic [2:0] done_sync_reg;
   logic [1:0] ss_sync_reg;
   wire        frm_evt = done_sync_reg[1] ^ done_sync_reg[2];

   // Frame-done toggle and select level each pass two flops first
   always_ff @(posedge clk) begin
      if (rst) begin
         done_sync_reg <= 3'b000;
         ss_sync_reg   <= 2'b11;
      end else begin
         done_sync_reg <= {done_sync_reg[1:0], done_tgl_reg};
         ss_sync_reg   <= {ss_sync_reg[0], slave_select_n};
      end
   end

   // ***********************
   // Decode
   // ***********************
   ssr_state_t  st_reg;
   ssr_reply_t  rep_pend_reg;
   ssr_ctl_t    ctl_reg;
   logic        req_reg;
   logic [15:0] status_reg;
   logic [15:0] count_reg;
   logic [5:0]  idx_reg;
   logic [5:0]  sidx_reg;
   logic [7:0]  left_reg;
   logic        seq_wr_reg;
   logic [31:0] buf_reg [BUF_WORDS];

   // Command, length and address checks, in that priority
   wire [15:0] f_adr   = frm_reg.w1;
   wire        is_rd   = frm_reg.cmd == CMD_RD;
   wire        is_wr   = frm_reg.cmd == CMD_WR;
   wire        is_sq   = frm_reg.cmd == CMD_SEQ_RD || frm_reg.cmd == CMD_SEQ_WR;
   wire        is_dt   = frm_reg.cmd == CMD_BUF_RD || frm_reg.cmd == CMD_BUF_WR;
   wire        len124  = frm_reg.len == 8'h01 || frm_reg.len == 8'h02 || frm_reg.len == 8'h04;
   wire        bad_cmd = !(is_rd || is_wr || is_sq || is_dt);
   wire        bad_len = (is_rd && !len124)
                      || (is_wr && frm_reg.len != 8'h01 && frm_reg.len != 8'h02)
                      || (is_sq && frm_reg.len == 8'h00)
                      || (is_dt && (frm_reg.len == 8'h00 || frm_reg.len > 8'h04));
   wire        bad_adr = ((is_rd || is_wr) && f_adr > ADR_MAX)
                      || (is_sq && f_adr > CTRL_MAX);
   wire        bad     = bad_cmd || bad_len || bad_adr;
   wire [15:0] bad_code = bad_cmd ? STS_CMD : (bad_len ? STS_LEN : STS_ADR);
   wire        is_ext  = f_adr >= EXT_BASE;
   wire        take    = frm_evt && st_reg == ST_IDLE;
   wire [8:0]  len_sum = {1'b0, frm_reg.len} + 9'h003;
   wire [6:0]  n_words = len_sum[8:2];

   // Extended register read selection, values right-justified
   wire [15:0] buf_off = f_adr - BUF_BASE;
   wire        in_buf  = f_adr >= BUF_BASE && f_adr <= BUF_LAST;
   wire [31:0] ext_rd  = f_adr == ADR_DEVID ? DEVICE_ID :
                         f_adr == ADR_VER   ? {16'h0000, REVISION} :
                         f_adr == ADR_STAT  ? {16'h0000, status_reg} :
                         f_adr == ADR_COUNT ? {16'h0000, count_reg} :
                         in_buf ? buf_reg[buf_off[7:2]] : 32'h0;
   wire [15:0] dt_adr  = BUF_BASE + {8'h00, idx_reg, 2'b00};

   // Sequential step: at most four bytes per controller access
   wire [7:0]  left_n  = left_reg - 8'h04;
   wire        seq_end = left_reg <= 8'h04;
   wire [2:0]  first_n = frm_reg.len >= 8'h04 ? 3'h4 : frm_reg.len[2:0];
   wire [2:0]  next_n  = left_n >= 8'h04 ? 3'h4 : left_n[2:0];
   wire [5:0]  sidx_n  = sidx_reg + 6'h01;

   // Buffer writes: staged words from the master or fetched controller data
   wire        buf_we  = (take && !bad && frm_reg.cmd == CMD_BUF_WR)
                      || (st_reg == ST_SEQ && ctl_ack && !seq_wr_reg);
   wire [5:0]  buf_wi  = st_reg == ST_SEQ ? sidx_reg : idx_reg;
   wire [31:0] buf_wd  = st_reg == ST_SEQ ? ctl_rdata : {frm_reg.w1, frm_reg.w2};

   // Natural values are placed flush left for short reads
   function automatic logic [31:0] ljust(input logic [31:0] v, input logic [7:0] n);
      ljust = n == 8'h01 ? {v[7:0], 24'h0} : (n == 8'h02 ? {v[15:0], 16'h0} : v);
   endfunction

   always_ff @(posedge clk) begin
      if (buf_we) begin
         buf_reg[buf_wi] <= buf_wd;
      end
   end

   // ***********************
   // Command engine
   // ***********************
   // Busy frames are refused as overrun; the engine keeps running meanwhile
   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg       <= ST_IDLE;
         rep_pend_reg <= '0;
         ctl_reg      <= '0;
         req_reg      <= 1'b0;
         status_reg   <= STS_OK;
         count_reg    <= 16'h0000;
         idx_reg      <= 6'h00;
         sidx_reg     <= 6'h00;
         left_reg     <= 8'h00;
         seq_wr_reg   <= 1'b0;
      end else begin
         if (frm_evt && st_reg != ST_IDLE) begin
            status_reg       <= STS_OVR;
            rep_pend_reg.err <= 1'b1;
         end
         case (st_reg)
            ST_IDLE: begin
               if (frm_evt && bad) begin
                  status_reg   <= bad_code;
                  rep_pend_reg <= {1'b1, 1'b0, f_adr[13:0], 32'h0};
               end else if (frm_evt && (is_rd || is_wr) && is_ext) begin
                  rep_pend_reg <= {1'b0, 1'b0, f_adr[13:0],
                                   is_rd ? ljust(ext_rd, frm_reg.len) : 32'h0};
                  if (is_wr && f_adr == ADR_CTRL && frm_reg.w2 == CTL_CLR) begin
                     status_reg <= STS_OK;
                  end
               end else if (frm_evt && (is_rd || is_wr)) begin
                  ctl_reg      <= {is_wr, f_adr, frm_reg.len[2:0], frm_reg.w2, 16'h0};
                  req_reg      <= 1'b1;
                  st_reg       <= ST_SINGLE;
                  rep_pend_reg <= {1'b0, 1'b1, f_adr[13:0], 32'h0};
               end else if (frm_evt && is_sq) begin
                  count_reg    <= {9'h000, n_words};
                  idx_reg      <= 6'h00;
                  sidx_reg     <= 6'h00;
                  left_reg     <= frm_reg.len;
                  seq_wr_reg   <= frm_reg.cmd == CMD_SEQ_WR;
                  ctl_reg      <= {frm_reg.cmd == CMD_SEQ_WR, f_adr, first_n, buf_reg[0]};
                  req_reg      <= 1'b1;
                  st_reg       <= ST_SEQ;
                  rep_pend_reg <= {1'b0, 1'b1, f_adr[13:0], 32'h0};
               end else if (frm_evt) begin
                  idx_reg      <= idx_reg + 6'h01;
                  rep_pend_reg <= {1'b0, 1'b0, dt_adr[13:0],
                                   frm_reg.cmd == CMD_BUF_RD ? buf_reg[idx_reg] : 32'h0};
               end
            end
            ST_SINGLE: begin
               if (ctl_ack) begin
                  req_reg           <= 1'b0;
                  st_reg            <= ST_IDLE;
                  rep_pend_reg.busy <= 1'b0;
                  rep_pend_reg.dat  <= ctl_reg.we ? 32'h0 : ctl_rdata;
               end
            end
            ST_SEQ: begin
               if (ctl_ack && seq_end) begin
                  req_reg           <= 1'b0;
                  st_reg            <= ST_IDLE;
                  rep_pend_reg.busy <= 1'b0;
               end else if (ctl_ack) begin
                  sidx_reg <= sidx_n;
                  left_reg <= left_n;
                  ctl_reg  <= {seq_wr_reg, ctl_reg.adr + 16'h0004, next_n, buf_reg[sidx_n]};
               end
            end
            default: st_reg <= ST_IDLE;
         endcase
      end
   end

   // Reply changes only between frames, so the link never shifts a torn word
   always_ff @(posedge clk) begin
      if (rst) begin
         reply_reg <= '0;
      end else if (ss_sync_reg[1]) begin
         reply_reg <= rep_pend_reg;
      end
   end

   assign ctl_o   = ctl_reg;
   assign ctl_req = req_reg;

   // ***********************
   // Checks
   // ***********************
   a_bad_flag: assert property (@(posedge clk) disable iff (rst)
      take && bad |=> rep_pend_reg.err && !rep_pend_reg.busy)
      else $error("bad frame without error flag");
   a_cmd_code: assert property (@(posedge clk) disable iff (rst)
      take && bad_cmd |=> status_reg == STS_CMD)
      else $error("wrong status for bad command");
   a_len_code: assert property (@(posedge clk) disable iff (rst)
      take && !bad_cmd && bad_len |=> status_reg == STS_LEN)
      else $error("wrong status for bad length");
   a_ovr_code: assert property (@(posedge clk) disable iff (rst)
      frm_evt && st_reg != ST_IDLE |=> status_reg == STS_OVR && rep_pend_reg.err)
      else $error("overrun not recorded");
   a_seq_count: assert property (@(posedge clk) disable iff (rst)
      take && !bad && is_sq |=> count_reg == {9'h000, $past(n_words)} && rep_pend_reg.busy)
      else $error("sequence count or busy wrong");
   a_req_hold: assert property (@(posedge clk) disable iff (rst)
      ctl_req && !ctl_ack |=> ctl_req && $stable(ctl_o))
      else $error("controller request dropped");
   a_busy_req: assert property (@(posedge clk) disable iff (rst)
      rep_pend_reg.busy |-> ctl_req)
      else $error("busy without pending access");
   a_dt_step: assert property (@(posedge clk) disable iff (rst)
      take && !bad && is_dt |=> idx_reg == $past(idx_reg) + 6'h01)
      else $error("buffer index did not advance");
endmodule

//--- design/ssr_pkg.sv
package ssr_pkg;
   // ***********************
   // Commands and status codes
   // ***********************
   localparam logic [7:0]  CMD_RD     = 8'h01;
   localparam logic [7:0]  CMD_WR     = 8'h02;
   localparam logic [7:0]  CMD_SEQ_RD = 8'h03;
   localparam logic [7:0]  CMD_SEQ_WR = 8'h04;
   localparam logic [7:0]  CMD_BUF_RD = 8'h05;
   localparam logic [7:0]  CMD_BUF_WR = 8'h06;
   localparam logic [15:0] STS_OK     = 16'h0000;
   localparam logic [15:0] STS_CMD    = 16'h0001;
   localparam logic [15:0] STS_LEN    = 16'h0002;
   localparam logic [15:0] STS_ADR    = 16'h0003;
   localparam logic [15:0] STS_OVR    = 16'h0011;
   localparam logic [15:0] CTL_CLR    = 16'h0001;
   // ***********************
   // Address map
   // ***********************
   localparam logic [15:0] ADR_MAX   = 16'h3FFF;
   localparam logic [15:0] CTRL_MAX  = 16'h2FFF;
   localparam logic [15:0] EXT_BASE  = 16'h3000;
   localparam logic [15:0] ADR_DEVID = 16'h3000;
   localparam logic [15:0] ADR_VER   = 16'h3004;
   localparam logic [15:0] ADR_STAT  = 16'h3006;
   localparam logic [15:0] ADR_CTRL  = 16'h3008;
   localparam logic [15:0] ADR_COUNT = 16'h301E;
   localparam logic [15:0] BUF_BASE  = 16'h3020;
   localparam logic [15:0] BUF_LAST  = 16'h311F;
   localparam int          BUF_WORDS = 64;
   localparam logic [5:0]  LAST_BIT  = 6'h2F;
   // ***********************
   // Carriers
   // ***********************
   typedef struct packed {
      logic [7:0]  cmd;
      logic [7:0]  len;
      logic [15:0] w1;
      logic [15:0] w2;
   } ssr_frame_t;
   typedef struct packed {
      logic        err;
      logic        busy;
      logic [13:0] adr;
      logic [31:0] dat;
   } ssr_reply_t;
   typedef struct packed {
      logic        we;
      logic [15:0] adr;
      logic [2:0]  len;
      logic [31:0] wdat;
   } ssr_ctl_t;
   typedef enum logic [1:0] {ST_IDLE, ST_SINGLE, ST_SEQ} ssr_state_t;
endpackage

//--- verif/ssr_ctl_model.sv
`timescale 1ns/1ns
// ****************
// Controller stand-in
// ****************
module ssr_ctl_model (
   // System
   input  wire logic              clk,
   input  wire logic              rst,
   // Access port
   input  wire ssr_pkg::ssr_ctl_t ctl_o,
   input  wire logic              ctl_req,
   output logic [31:0]            ctl_rdata,
   output logic                   ctl_ack
);
   import ssr_pkg::*;
   logic [7:0]  mem [0:12287];
   logic [1:0]  wait_cnt;
   logic        slow;
   logic [31:0] noise = 32'h0;
   // Byte pattern that the bench recomputes on its own
   initial begin
      for (int i = 0; i < 12288; i++) begin
         mem[i] = i[7:0] ^ i[15:8] ^ 8'h5A;
      end
   end
   // Prompt and slow answers alternate; data lines churn outside the ack cycle
   always @(posedge clk) begin
      noise     <= {noise[30:0], ~noise[31]};
      ctl_ack   <= 1'b0;
      ctl_rdata <= noise;
      if (rst) begin
         wait_cnt <= 2'h0;
         slow     <= 1'b0;
      end else if (ctl_req && !ctl_ack) begin
         if (wait_cnt == (slow ? 2'h3 : 2'h0)) begin
            ctl_ack  <= 1'b1;
            wait_cnt <= 2'h0;
            slow     <= ~slow;
            for (int k = 0; k < 4; k++) begin
               ctl_rdata[31-8*k -: 8] <= (k < ctl_o.len) ? mem[ctl_o.adr + k] : 8'h00;
               if (ctl_o.we && k < ctl_o.len) begin
                  mem[ctl_o.adr + k] <= ctl_o.wdat[31-8*k -: 8];
               end
            end
         end else begin
            wait_cnt <= wait_cnt + 2'h1;
         end
      end
   end
endmodule

//--- verif/spi_slave_register_access_cmds_bench.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_total++; \
   $display("BAD %0t got %h exp %h", $time, got, exp); end end
module spi_slave_register_access_cmds_bench;
   import ssr_pkg::*;
   localparam logic [31:0] DEV_ID = 32'h1234_ABCD; // Arbitrary value
   localparam logic [15:0] BENCH_REV = 16'h00A5; // Arbitrary value
   logic        clk, rst, sck, ssn, mosi, miso, ctl_req, ctl_ack;
   logic [31:0] ctl_rdata;
   ssr_ctl_t    ctl_o;
   logic [47:0] r, d;
   int          err_total, checks;
   int          cyc = 0;
   ssr_cmd_top #(.DEVICE_ID(DEV_ID), .REVISION(BENCH_REV)) dut_u (.clk(clk), .rst(rst),
      .serial_clock_in(sck), .slave_select_n(ssn), .mosi(mosi), .miso(miso), .ctl_o(ctl_o),
      .ctl_req(ctl_req), .ctl_rdata(ctl_rdata), .ctl_ack(ctl_ack));
   ssr_ctl_model ctl_u (.clk(clk), .rst(rst), .ctl_o(ctl_o), .ctl_req(ctl_req),
      .ctl_rdata(ctl_rdata), .ctl_ack(ctl_ack));
   // ****************
   // Helpers
   // ****************
   function automatic logic [7:0] eb(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5A;
   endfunction
   // One 48-bit frame; link clock runs only inside it, mosi moves after each fall
   task automatic frame(input logic [47:0] tx, output logic [47:0] rx);
      @(posedge clk);
      #2 ssn = 1'b0;
      mosi = tx[47];
      #400;
      for (int i = 47; i >= 0; i--) begin
         #30 sck = 1'b1;
         #32 sck = 1'b0;
         rx = {rx[46:0], miso};
         #2 mosi = (i > 0) ? tx[i-1] : ~tx[0];
      end
      #30 ssn = 1'b1;
      repeat (10) @(posedge clk);
      `CHK(miso, 1'b0)
   endtask
   // Busy is not polled over the link: a frame sent while busy would be refused
   task automatic idle;
      int n, q;
      n = 0;
      q = 0;
      while (n < 3000 && q < 6) begin
         @(posedge clk);
         #2 q = (ctl_req === 1'b0) ? q + 1 : 0;
         n++;
      end
   endtask
   // Command, wait, then a status read whose reply carries the command result
   task automatic op(input logic [7:0] c, input logic [7:0] l, input logic [15:0] a,
                     input logic [15:0] w);
      frame({c, l, a, w}, d);
      idle;
      frame({CMD_RD, 8'h02, ADR_STAT, 16'h0}, r);
   endtask
   task automatic chk_sts(input logic [15:0] code);
      op(CMD_RD, 8'h02, ADR_STAT, 16'h0);
      `CHK(r[31:16], code)
   endtask
   // ****************
   // Scenarios
   // ****************
   task automatic t_reset;
      op(CMD_RD, 8'h04, ADR_DEVID, 16'h0);
      `CHK(d, 48'h0)
      `CHK(r, {2'b00, ADR_DEVID[13:0], DEV_ID})
      op(CMD_RD, 8'h02, ADR_VER, 16'h0);
      `CHK(r[31:16], BENCH_REV)
   endtask
   task automatic t_seq_write;
      op(CMD_BUF_WR, 8'h04, 16'hDEAD, 16'hBEEF);
      op(CMD_BUF_WR, 8'h04, 16'h0123, 16'h4567);
      op(CMD_SEQ_WR, 8'h08, 16'h0100, 16'h0);
      `CHK(r[47:32], 16'h0100)
      op(CMD_RD, 8'h04, 16'h0104, 16'h0);
      `CHK(r[31:0], 32'h01234567)
      op(CMD_WR, 8'h02, BUF_BASE, 16'h0000);
      op(CMD_RD, 8'h04, BUF_BASE, 16'h0);
      `CHK(r[31:0], 32'hDEADBEEF)
      op(CMD_RD, 8'h02, ADR_COUNT, 16'h0);
      `CHK(r[31:16], 16'h0002)
   endtask
   task automatic t_single;
      op(CMD_RD, 8'h01, 16'h0203, 16'h0);
      `CHK(r, {16'h0203, eb(16'h0203), 24'h0})
      op(CMD_RD, 8'h02, 16'h0302, 16'h0);
      `CHK(r, {16'h0302, eb(16'h0302), eb(16'h0303), 16'h0})
      op(CMD_RD, 8'h04, 16'h2FFC, 16'h0);
      `CHK(r[31:0], {eb(16'h2FFC), eb(16'h2FFD), eb(16'h2FFE), eb(16'h2FFF)})
      op(CMD_WR, 8'h01, 16'h0500, 16'hAB00);
      `CHK(r[47:32], 16'h0500)
      op(CMD_WR, 8'h02, 16'h0502, 16'h1357);
      op(CMD_RD, 8'h04, 16'h0500, 16'h0);
      `CHK(r[31:0], {8'hAB, eb(16'h0501), 16'h1357})
      op(CMD_RD, 8'h02, 16'h3FFE, 16'h0);
      `CHK(r[47:46], 2'b00)
   endtask
   task automatic t_seq_read;
      logic [15:0] a;
      op(CMD_SEQ_RD, 8'h0A, 16'h0200, 16'h0);
      `CHK(r[47:32], 16'h0200)
      op(CMD_RD, 8'h02, ADR_COUNT, 16'h0);
      `CHK(r[31:16], 16'h0003)
      for (int i = 0; i < 3; i++) begin
         a = 16'h0200 + 16'(4 * i);
         op(CMD_BUF_RD, (i == 2) ? 8'h02 : 8'h04, 16'h0, 16'h0);
         `CHK(r[45:32], BUF_BASE[13:0] + 14'(4 * i))
         `CHK(r[31:16], {eb(a), eb(a + 16'h1)})
         if (i < 2) `CHK(r[15:0], {eb(a + 16'h2), eb(a + 16'h3)})
      end
      op(CMD_RD, 8'h04, BUF_BASE + 16'h4, 16'h0);
      `CHK(r[31:0], {eb(16'h0204), eb(16'h0205), eb(16'h0206), eb(16'h0207)})
   endtask
   task automatic t_errors;
      logic [7:0]  ec [5] = '{8'h07, CMD_RD, CMD_WR, CMD_SEQ_RD, CMD_RD};
      logic [7:0]  el [5] = '{8'h01, 8'h03, 8'h04, 8'h04, 8'h01};
      logic [15:0] ea [5] = '{16'h0, 16'h0, 16'h0, 16'h3000, 16'h4000};
      logic [15:0] es [5] = '{STS_CMD, STS_LEN, STS_LEN, STS_ADR, STS_ADR};
      for (int i = 0; i < 5; i++) begin
         op(ec[i], el[i], ea[i], 16'h0);
         `CHK(r[47:46], 2'b10)
         chk_sts(es[i]);
      end
      op(CMD_WR, 8'h02, ADR_CTRL, CTL_CLR);
      chk_sts(STS_OK);
   endtask
   // A frame sent while a long sequential read runs is refused
   task automatic t_overrun;
      frame({CMD_SEQ_RD, 8'hFF, 16'h0000, 16'h0}, d);
      frame({CMD_RD, 8'h02, ADR_STAT, 16'h0}, d);
      `CHK(d[47:46], 2'b01)
      idle;
      chk_sts(STS_OVR);
      op(CMD_RD, 8'h02, ADR_COUNT, 16'h0);
      `CHK(r[31:16], 16'h0040)
      op(CMD_RD, 8'h04, 16'h311C, 16'h0);
      `CHK(r[31:8], {eb(16'h00FC), eb(16'h00FD), eb(16'h00FE)})
      op(CMD_WR, 8'h02, ADR_CTRL, CTL_CLR);
   endtask
   task test_done;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ****************
   // Run
   // ****************
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Ceiling well above the roughly 4000 cycles the scenarios need
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         test_done;
      end
   end
   initial begin
      rst = 1'b1;
      sck = 1'b0;
      ssn = 1'b1;
      mosi = 1'b0;
      err_total = 0;
      checks = 0;
      repeat (6) @(posedge clk);
      #2 rst = 1'b0;
      repeat (5) @(posedge clk);
      t_reset;
      t_seq_write;
      t_single;
      t_seq_read;
      t_errors;
      t_overrun;
      test_done;
   end
endmodule
